// ---- inc/ctsmf_defs.vh ----
`ifndef CTSMF_DEFS_VH
`define CTSMF_DEFS_VH

// ----------------------------------------------------------------------
// Operating mode encoding
// ----------------------------------------------------------------------
`define CTSMF_MODE_W          2
`define CTSMF_MODE_UNPOWERED  2'h0
`define CTSMF_MODE_STANDBY    2'h1
`define CTSMF_MODE_SILENT     2'h2
`define CTSMF_MODE_NORMAL     2'h3

// ----------------------------------------------------------------------
// Time base and timer counts
// ----------------------------------------------------------------------
`define CTSMF_CLK_PERIOD_NS   8
`define CTSMF_TXD_REL_MIN_NS  4000
`define CTSMF_TXD_REL_CYC     ((`CTSMF_TXD_REL_MIN_NS + `CTSMF_CLK_PERIOD_NS - 1) / `CTSMF_CLK_PERIOD_NS)
`define CTSMF_CNT_W           20
`define CTSMF_WAKE_FILT_CYC   63
`define CTSMF_TXD_DOM_TO_CYC  100000
`define CTSMF_BUS_WAKE_TO_CYC 100000
`define CTSMF_CLAMP_DET_CYC   10

`endif

// ---- src/ctsmf_timer.v ----
`timescale 1ns/1ns

// Saturating run-length timer: counts cycles while run is high, clears
// on the first clock edge with run low, and flags once the limit has been reached.
module ctsmf_timer #(
  parameter LIMIT = 16
) (
  input  wire ref_clk_i,
  input  wire reset_i,
  input  wire run_i,
  output wire expired_o
);

  reg  [19:0] count_r;
  wire [19:0] limit_w;

  assign limit_w   = LIMIT[19:0];
  assign expired_o = (count_r >= limit_w);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_r <= 20'h00000;
    end else if (!run_i) begin
      count_r <= 20'h00000;
    end else if (count_r < limit_w) begin
      count_r <= count_r + 20'h00001;
    end
  end

endmodule // ctsmf_timer

// ---- src/ctsmf_core.v ----
`timescale 1ns/1ns
`include "ctsmf_defs.vh"

// Operation
// - Standby and silent inputs low give Silent: no transmit, bus recessive, receive live.
// - Silent keeps the fast comparator and everything else but the transmitter running.
// - Standby input high selects Standby; transmitter and fast comparator are off.
// - In Standby, dominant longer than wake filter after recessive pulls receive low.
// - In Standby the bus is biased to ground instead of half supply.
// - A wake request never leaves Standby; the controller drops the standby input.
// - Transmit low beyond the dominant time-out disables the transmitter.
// - Dominant time-out clears only after transmit input high for 4 us.
// - Unconnected transmit, standby and silent inputs read as high.
// - Any supply undervoltage switches the device off until both supplies recover.
// - Wake comparator stays on except during supply undervoltage.
// - Standby input is ignored during undervoltage and used again after recovery.
// - In Standby, dominant beyond bus wake time-out forces receive output high.
// - Bus return to recessive resets the bus wake timer and re-arms wake detection.
// - Overtemperature disables drivers until flag clears and transmit input is high.
// - Fast comparator dominant without receive low beyond clamp time forces Silent.
// - Forced Silent ends on Standby, Unpowered, or receive output low again.
// - Normal needs standby low, transmit and silent high; refused while transmit low.
// - Normal drives bus from transmit input and mirrors bus on receive output.
module ctsmf_core #(
  parameter WAKE_FILT_CYC   = `CTSMF_WAKE_FILT_CYC,
  parameter TXD_DOM_TO_CYC  = `CTSMF_TXD_DOM_TO_CYC,
  parameter BUS_WAKE_TO_CYC = `CTSMF_BUS_WAKE_TO_CYC,
  parameter CLAMP_DET_CYC   = `CTSMF_CLAMP_DET_CYC
) (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       txd_i,
  input  wire       txd_float_i,
  input  wire       standby_ctrl_in_i,
  input  wire       standby_float_i,
  input  wire       silent_ctrl_n_i,
  input  wire       silent_float_i,
  input  wire       core_uv_i,
  input  wire       io_supply_uv_i,
  input  wire       overtemp_i,
  input  wire       fast_bus_comparator_i,
  input  wire       wakeup_comparator_i,
  input  wire       rxd_pin_i,
  output reg        tx_dominant_o,
  output reg        rxd_o,
  output reg        bias_half_o,
  output reg        bias_gnd_o,
  output reg        fast_cmp_en_o,
  output reg        wakeup_cmp_en_o,
  output reg  [1:0] mode_o,
  output reg        clamp_silent_o,
  output reg        tx_timeout_o,
  output reg        overtemp_lock_o,
  output reg        wake_req_o
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // True in the two modes where the fast comparator and receive path run
  function is_active;
    input [1:0] m;
    begin
      is_active = (m == `CTSMF_MODE_NORMAL) || (m == `CTSMF_MODE_SILENT);
    end
  endfunction

  // --------------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------------

  wire txd_eff;
  wire standby_ctrl_in_eff;
  wire sil_n_eff;
  wire uv_any;

  assign txd_eff   = txd_i | txd_float_i;
  assign standby_ctrl_in_eff  = standby_ctrl_in_i | standby_float_i;
  assign sil_n_eff = silent_ctrl_n_i | silent_float_i;

  assign uv_any = core_uv_i | io_supply_uv_i;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------

  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg       clamp_r;
  reg       clamp_nxt;
  reg       txd_to_r;
  reg       txd_to_nxt;
  reg       ot_lock_r;
  reg       ot_lock_nxt;
  reg       wake_armed_r;
  reg       wake_armed_nxt;
  reg       wake_req_r;
  reg       wake_req_nxt;
  reg       bus_to_r;
  reg       bus_to_nxt;

  wire in_standby;
  wire wuc_dom;

  assign in_standby = (mode_r == `CTSMF_MODE_STANDBY);
  assign wuc_dom    = wakeup_comparator_i & ~uv_any;

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------

  wire dom_exp;
  wire rel_exp;
  wire wake_exp;
  wire bus_exp;
  wire clamp_exp;

  ctsmf_timer #(
    .LIMIT (TXD_DOM_TO_CYC)
  ) u_txd_dom (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (~txd_eff & ~uv_any),
    .expired_o (dom_exp)
  );

  ctsmf_timer #(
    .LIMIT (`CTSMF_TXD_REL_CYC)
  ) u_txd_rel (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (txd_eff & txd_to_r),
    .expired_o (rel_exp)
  );

  ctsmf_timer #(
    .LIMIT (WAKE_FILT_CYC)
  ) u_wake (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (in_standby & wuc_dom & wake_armed_r),
    .expired_o (wake_exp)
  );

  ctsmf_timer #(
    .LIMIT (BUS_WAKE_TO_CYC)
  ) u_bus_to (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (in_standby & wuc_dom & wake_armed_r),
    .expired_o (bus_exp)
  );

  // Clamp detect: bus dominant, receive pin not following
  ctsmf_timer #(
    .LIMIT (CLAMP_DET_CYC)
  ) u_clamp (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (is_active(mode_r) & fast_bus_comparator_i & rxd_pin_i),
    .expired_o (clamp_exp)
  );

  // --------------------------------------------------------------------
  // Mode selection
  // --------------------------------------------------------------------

  always @* begin
    mode_nxt = mode_r;
    if (uv_any) begin
      mode_nxt = `CTSMF_MODE_UNPOWERED;
    end else begin
      case (mode_r)
        `CTSMF_MODE_UNPOWERED,
        `CTSMF_MODE_STANDBY,
        `CTSMF_MODE_SILENT,
        `CTSMF_MODE_NORMAL: begin
          if (standby_ctrl_in_eff) begin
            mode_nxt = `CTSMF_MODE_STANDBY;
          end else if (!sil_n_eff) begin
            mode_nxt = `CTSMF_MODE_SILENT;
          end else if (txd_eff) begin
            mode_nxt = `CTSMF_MODE_NORMAL;
          // Transmit low keeps the present mode, except Unpowered goes to Standby
          end else if (mode_r == `CTSMF_MODE_UNPOWERED) begin
            mode_nxt = `CTSMF_MODE_STANDBY;
          end else begin
            mode_nxt = mode_r;
          end
        end
        default: begin
          mode_nxt = `CTSMF_MODE_UNPOWERED;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Fail-safe flags
  // --------------------------------------------------------------------

  always @* begin
    txd_to_nxt = txd_to_r;
    if (dom_exp) begin
      txd_to_nxt = 1'b1;
    end else if (rel_exp) begin
      txd_to_nxt = 1'b0;
    end

    ot_lock_nxt = ot_lock_r;
    if (overtemp_i) begin
      ot_lock_nxt = 1'b1;
    end else if (txd_eff) begin
      ot_lock_nxt = 1'b0;
    end

    clamp_nxt = clamp_r;
    if (clamp_exp && is_active(mode_nxt)) begin
      clamp_nxt = 1'b1;
    end else if (!is_active(mode_nxt) || !rxd_pin_i) begin
      clamp_nxt = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Standby wake detection
  // --------------------------------------------------------------------

  // Arming needs a recessive bus first, so a bus already dominant when
  // Standby is entered is not taken as a wake-up.
  always @* begin
    wake_armed_nxt = wake_armed_r;
    wake_req_nxt   = wake_req_r;
    bus_to_nxt     = bus_to_r;
    if (!in_standby || mode_nxt != `CTSMF_MODE_STANDBY) begin
      wake_armed_nxt = 1'b0;
      wake_req_nxt   = 1'b0;
      bus_to_nxt     = 1'b0;
    end else if (!wuc_dom) begin
      wake_armed_nxt = 1'b1;
      bus_to_nxt     = 1'b0;
    end else begin
      if (wake_exp && !bus_to_r) begin
        wake_req_nxt = 1'b1;
      end
      // Clamped dominant bus stops the request
      if (bus_exp) begin
        bus_to_nxt   = 1'b1;
        wake_req_nxt = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode_r       <= `CTSMF_MODE_UNPOWERED;
      clamp_r      <= 1'b0;
      txd_to_r     <= 1'b0;
      ot_lock_r    <= 1'b0;
      wake_armed_r <= 1'b0;
      wake_req_r   <= 1'b0;
      bus_to_r     <= 1'b0;
    end else begin
      mode_r       <= mode_nxt;
      clamp_r      <= clamp_nxt;
      txd_to_r     <= txd_to_nxt;
      ot_lock_r    <= ot_lock_nxt;
      wake_armed_r <= wake_armed_nxt;
      wake_req_r   <= wake_req_nxt;
      bus_to_r     <= bus_to_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------

  // Outputs are registered from the next-state values, so the pins move
  // in the same cycle as the internal state and never glitch.
  wire tx_allowed;
  reg  rxd_nxt;

  assign tx_allowed = (mode_nxt == `CTSMF_MODE_NORMAL) & ~clamp_nxt & ~txd_to_nxt & ~ot_lock_nxt;

  always @* begin
    case (mode_nxt)
      `CTSMF_MODE_NORMAL,
      `CTSMF_MODE_SILENT: begin
        rxd_nxt = ~fast_bus_comparator_i;
      end
      `CTSMF_MODE_STANDBY: begin
        rxd_nxt = ~wake_req_nxt;
      end
      default: begin
        rxd_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_dominant_o   <= 1'b0;
      rxd_o           <= 1'b1;
      bias_half_o     <= 1'b0;
      bias_gnd_o      <= 1'b0;
      fast_cmp_en_o   <= 1'b0;
      wakeup_cmp_en_o <= 1'b0;
      mode_o          <= `CTSMF_MODE_UNPOWERED;
      clamp_silent_o  <= 1'b0;
      tx_timeout_o    <= 1'b0;
      overtemp_lock_o <= 1'b0;
      wake_req_o      <= 1'b0;
    end else begin
      tx_dominant_o   <= tx_allowed & ~txd_eff;
      rxd_o           <= rxd_nxt;
      bias_half_o     <= is_active(mode_nxt);
      bias_gnd_o      <= (mode_nxt == `CTSMF_MODE_STANDBY);
      // Fast comparator off outside active modes
      fast_cmp_en_o   <= is_active(mode_nxt);
      // Wake comparator off only on undervoltage
      wakeup_cmp_en_o <= ~uv_any;
      mode_o          <= mode_nxt;
      clamp_silent_o  <= clamp_nxt;
      tx_timeout_o    <= txd_to_nxt;
      overtemp_lock_o <= ot_lock_nxt;
      wake_req_o      <= wake_req_nxt;
    end
  end

endmodule // ctsmf_core

// ---- tb/ctsmf_checker.sv ----
`timescale 1ns/1ns
module ctsmf_checker (
  input wire       ref_clk_i,
  input wire       reset_i,
  input wire       txd_i,
  input wire       txd_float_i,
  input wire       standby_ctrl_in_i,
  input wire       standby_float_i,
  input wire       silent_ctrl_n_i,
  input wire       silent_float_i,
  input wire       core_uv_i,
  input wire       io_supply_uv_i,
  input wire       overtemp_i,
  input wire       fast_bus_comparator_i,
  input wire       wakeup_comparator_i,
  input wire       rxd_pin_i,
  input wire       tx_dominant_o,
  input wire       rxd_o,
  input wire       bias_half_o,
  input wire       bias_gnd_o,
  input wire       fast_cmp_en_o,
  input wire       wakeup_cmp_en_o,
  input wire [1:0] mode_o,
  input wire       clamp_silent_o,
  input wire       tx_timeout_o,
  input wire       overtemp_lock_o,
  input wire       wake_req_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire       uv  = core_uv_i | io_supply_uv_i;
  wire       txh = txd_i | txd_float_i;
  reg  [9:0] hi_r;
  // Saturating run length of a high transmit input
  always @(posedge ref_clk_i) begin
    if (reset_i || !txh)
      hi_r <= 10'h0;
    else if (hi_r != 10'h3ff)
      hi_r <= hi_r + 10'h1;
  end
  silent_no_tx_a: assert property (mode_o == 2'h2 |-> !tx_dominant_o)
    else $error("transmit driven in silent");
  silent_rx_a: assert property (mode_o == 2'h2 && $past(mode_o) == 2'h2
    |-> rxd_o == !$past(fast_bus_comparator_i)) else $error("silent receive dead");
  standby_ctrl_in_off_a: assert property (mode_o == 2'h1
    |-> !fast_cmp_en_o && !tx_dominant_o && bias_gnd_o && !bias_half_o)
    else $error("standby state wrong");
  wake_rxd_a: assert property (wake_req_o |-> !rxd_o)
    else $error("wake request not on receive");
  standby_ctrl_in_hold_a: assert property (mode_o == 2'h1 && standby_ctrl_in_i && !uv
    |=> mode_o == 2'h1) else $error("left standby alone");
  tout_off_a: assert property (tx_timeout_o |-> !tx_dominant_o)
    else $error("driving after time-out");
  tout_rel_a: assert property (!$past(reset_i) && !$past(uv) && $fell(tx_timeout_o)
    |-> hi_r >= 10'h1f3) else $error("time-out released early");
  uv_off_a: assert property (uv |=> mode_o == 2'h0 && !tx_dominant_o)
    else $error("active in undervoltage");
  wcmp_uv_a: assert property (!$past(reset_i) |-> wakeup_cmp_en_o == !$past(uv))
    else $error("wake comparator enable wrong");
  ot_lock_a: assert property (overtemp_i |=> overtemp_lock_o && !tx_dominant_o)
    else $error("overtemperature not locked");
  clamp_tx_a: assert property (clamp_silent_o |-> !tx_dominant_o)
    else $error("driving while clamped");
  // The clamp timer flag lags one cycle, so release shows after two low samples
  clamp_rel_a: assert property (!rxd_pin_i [*2] |=> !clamp_silent_o)
    else $error("clamp not released");
  no_normal_a: assert property (mode_o != 2'h3 && !txh |=> mode_o != 2'h3)
    else $error("normal entered with transmit low");
  norm_rx_a: assert property (mode_o == 2'h3 && $past(mode_o) == 2'h3
    |-> rxd_o == !$past(fast_bus_comparator_i)) else $error("normal receive wrong");
endmodule // ctsmf_checker

bind ctsmf_core ctsmf_checker u_chk (.*);

// ---- tb/ctsmf_ctrl_model.sv ----
`timescale 1ns/1ns
module ctsmf_ctrl_model (
  input  wire rxd_i,
  input  wire txd_req_i,
  input  wire standby_ctrl_in_req_i,
  input  wire sil_n_req_i,
  input  wire clamp_i,
  output wire txd_o,
  output wire standby_o,
  output wire silent_n_o,
  output wire rxd_pin_o
);
  assign txd_o     = txd_req_i;
  assign standby_o = standby_ctrl_in_req_i;
  assign silent_n_o = standby_ctrl_in_req_i | sil_n_req_i;
  // Board fault: the receive line stuck recessive
  assign rxd_pin_o = clamp_i | rxd_i;
endmodule // ctsmf_ctrl_model

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  reg         clk = 0, rst = 1, txd = 1, txf = 0, stb = 0, stf = 0, snl = 1, snf = 0;
  reg         cuv = 0, iuv = 0, ot = 0, fb = 0, wb = 0, clp = 0, b;
  wire        txp, stp, snp, rxp, td, rx, bh, bg, fe, we, cs, to, ol, wr;
  wire [1:0]  md;
  wire [11:0] obs = {md, rx, td, bh, bg, fe, we, cs, to, ol, wr};
  reg  [23:0] q[$];
  reg  [23:0] e;
  int         n_errors = 0, checks_done = 0, k;
  ctsmf_core #(.WAKE_FILT_CYC(20), .TXD_DOM_TO_CYC(50), .BUS_WAKE_TO_CYC(60),
    .CLAMP_DET_CYC(5)) i_dut (.ref_clk_i(clk), .reset_i(rst), .txd_i(txp),
    .txd_float_i(txf), .standby_ctrl_in_i(stp), .standby_float_i(stf),
    .silent_ctrl_n_i(snp), .silent_float_i(snf), .core_uv_i(cuv),
    .io_supply_uv_i(iuv), .overtemp_i(ot), .fast_bus_comparator_i(fb),
    .wakeup_comparator_i(wb), .rxd_pin_i(rxp), .tx_dominant_o(td), .rxd_o(rx),
    .bias_half_o(bh), .bias_gnd_o(bg), .fast_cmp_en_o(fe), .wakeup_cmp_en_o(we),
    .mode_o(md), .clamp_silent_o(cs), .tx_timeout_o(to), .overtemp_lock_o(ol),
    .wake_req_o(wr));
  ctsmf_ctrl_model i_ctl (.rxd_i(rx), .txd_req_i(txd), .standby_ctrl_in_req_i(stb),
    .sil_n_req_i(snl), .clamp_i(clp), .txd_o(txp), .standby_o(stp),
    .silent_n_o(snp), .rxd_pin_o(rxp));
  initial forever #4 clk = ~clk;
  task cyc(input int n); repeat (n) @(negedge clk); endtask
  task ex(input [11:0] m, input [11:0] v); q.push_back({m, v}); endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Watcher: outputs against the oldest note
  // ----------------------------------------------------------------
  initial forever begin
    @(negedge clk);
    #1;
    while (q.size() > 0) begin
      e = q.pop_front();
      `CHK(obs & e[23:12], e[11:0])
    end
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    b = $urandom(32'h0533);
    cyc(2); ex(12'hfff, 12'h200); cyc(2); rst = 0;
    cyc(2); ex(12'hfff, 12'heb0);
    repeat (8) begin
      b = $urandom % 2; txd = b; fb = !b;
      cyc(2); ex(12'h300, {2'h0, b, !b, 8'h0});
    end
    txd = 0; fb = 1; cyc(45); ex(12'h104, 12'h100);
    cyc(7); ex(12'h104, 12'h004);
    txd = 1; fb = 0; cyc(500); ex(12'h004, 12'h004);
    cyc(1); ex(12'h004, 12'h000);
    txd = 0; txf = 1; cyc(2); ex(12'h100, 12'h000);
    txf = 0; snl = 0; fb = 1; cyc(2); ex(12'hf00, 12'h800);
    fb = 0; cyc(2); ex(12'he20, 12'ha20);
    snl = 1; cyc(2); ex(12'hc00, 12'h800);
    txd = 1; cyc(2); ex(12'hc00, 12'hc00);
    txd = 0; clp = 1; fb = 1; cyc(8); ex(12'hd08, 12'hc08);
    clp = 0; cyc(3); ex(12'h108, 12'h100);
    fb = 0; ot = 1; cyc(2); ex(12'h102, 12'h002);
    ot = 0; cyc(3); ex(12'h002, 12'h002);
    txd = 1; cyc(2); ex(12'h002, 12'h000);
    stb = 1; cyc(2); ex(12'hfff, 12'h650);
    wb = 1; cyc(17); ex(12'h001, 12'h000);
    cyc(6); ex(12'he01, 12'h401);
    cyc(42); ex(12'h201, 12'h200);
    wb = 0; cyc(2); wb = 1; cyc(23); ex(12'h201, 12'h001);
    wb = 0; cyc(2); ex(12'hc01, 12'h401);
    stb = 0; cyc(2); ex(12'hc01, 12'hc00);
    for (k = 0; k < 2; k++) begin
      cuv = (k == 0); iuv = (k == 1); cyc(2); ex(12'hc10, 12'h000);
      stb = 1; cyc(2); ex(12'hc10, 12'h000);
      cuv = 0; iuv = 0; cyc(2); ex(12'hc10, 12'h410);
      stb = 0; cyc(2); ex(12'hc00, 12'hc00);
    end
    // Open standby and silent pins must read high
    stf = 1; cyc(2); ex(12'hc00, 12'h400);
    stf = 0; snl = 0; snf = 1; cyc(2); ex(12'hc00, 12'hc00);
    snf = 0; cyc(2); ex(12'hc00, 12'h800);
    snl = 1; rst = 1; cyc(2); ex(12'hfff, 12'h200);
    rst = 0; cyc(2); ex(12'hfff, 12'heb0);
    cyc(2);
    report_and_stop;
  end
endmodule // tb
